//--- vmc_pkg.sv
package vmc_pkg;
  // ==========================================================
  // Register map
  localparam logic [4:0]  VMC_REG_ADDR   = 5'h10;
  localparam logic [15:0] VMC_RESET_VAL  = 16'h0140;
  localparam int          VMC_REPEAT_BIT  = 15;
  localparam int          VMC_IRQPOL_BIT  = 14;
  localparam int          VMC_TXHIZ_BIT   = 12;
  localparam int          VMC_SQEINH_BIT  = 11;
  localparam int          VMC_NATLOOP_BIT = 10;
  localparam int          VMC_APDIS_BIT   = 5;
  localparam int          VMC_RXPOL_BIT   = 4;
  localparam int          VMC_BYPASS_BIT  = 1;
  localparam int          VMC_RXGATE_BIT  = 0;
  localparam logic [3:0]  VMC_RSVD96_VAL = 4'h5;
  localparam logic [1:0]  VMC_RSVD32_VAL = 2'h0;
  // ==========================================================
  // Timing
  localparam int          VMC_CLK_NS     = 100;
  localparam int          VMC_SQE_NS     = 1000;
  localparam logic [3:0]  VMC_SQE_CYCLES =
    4'((VMC_SQE_NS + VMC_CLK_NS - 1) / VMC_CLK_NS);
endpackage : vmc_pkg

`timescale 1ns/1ps
module vmc_autopol (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Control
  input  wire logic detectEnable,
  input  wire logic reversedSeen,
  // Status
  output logic      autoInvert
);
  import vmc_pkg::*;
  logic autoInvert_reg;
  logic autoInvert_next;

  always_comb begin
    autoInvert_next = autoInvert_reg;
    if (detectEnable) begin
      autoInvert_next = reversedSeen;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      autoInvert_reg <= 1'b0;
    end else begin
      autoInvert_reg <= autoInvert_next;
    end
  end

  assign autoInvert = autoInvert_reg;
endmodule : vmc_autopol

//--- vmc_mode_control.sv
`timescale 1ns/1ps
module vmc_mode_control (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Management register port
  input  wire logic [4:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [15:0] regWrData,
  output logic [15:0]     regRdData,
  output logic            regRdValid,
  // PHY operating state
  input  wire logic       mode10m,
  input  wire logic       mode100,
  input  wire logic       loopbackSelect,
  input  wire logic       duplexRequest,
  input  wire logic       rxActive,
  input  wire logic       txActive,
  input  wire logic       txDone,
  input  wire logic       polarityReversed,
  input  wire logic       irqEvent,
  // Transmit line
  input  wire logic       txPosData,
  input  wire logic       txNegData,
  output logic            txPosPin,
  output logic            txPosPinOe,
  output logic            txNegPin,
  output logic            txNegPinOe,
  // Receive path
  input  wire logic [3:0] macTxData,
  input  wire logic       macTxEn,
  input  wire logic [3:0] lineRxData,
  input  wire logic       lineRxDv,
  input  wire logic       lineRxBit,
  output logic [3:0]      rxData,
  output logic            rxDv,
  output logic            rxBitCorrected,
  // Mode outputs
  output logic            fullDuplex,
  output logic            carrierSense,
  output logic            phyIrq,
  output logic            sqePulse,
  output logic            pcsBypass,
  output logic            rxClockEnable
);
  import vmc_pkg::*;

  // ==========================================================
  // Register state
  logic        repeater_reg, repeater_next;
  logic        irqPol_reg, irqPol_next;
  logic        txHiz_reg, txHiz_next;
  logic        sqeInh_reg, sqeInh_next;
  logic        natLoop_reg, natLoop_next;
  logic        apDis_reg, apDis_next;
  logic        rvsForce_reg, rvsForce_next;
  logic        bypass_reg, bypass_next;
  logic        rxGate_reg, rxGate_next;
  logic [15:0] rdData_reg, rdData_next;
  logic        rdValid_reg, rdValid_next;
  logic        autoInvert;
  logic        rxInvert;
  logic [15:0] readView;
  logic        hit;

  vmc_autopol u_autopol (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .detectEnable (mode10m & ~apDis_reg),
    .reversedSeen (polarityReversed),
    .autoInvert   (autoInvert)
  );

  assign rxInvert = apDis_reg ? rvsForce_reg : autoInvert;
  assign hit      = (regAddr == VMC_REG_ADDR);

  always_comb begin
    readView = 16'h0000;
    readView[VMC_REPEAT_BIT]  = repeater_reg;
    readView[VMC_IRQPOL_BIT]  = irqPol_reg;
    readView[VMC_TXHIZ_BIT]   = txHiz_reg;
    readView[VMC_SQEINH_BIT]  = sqeInh_reg;
    readView[VMC_NATLOOP_BIT] = natLoop_reg;
    readView[9:6]             = VMC_RSVD96_VAL;
    readView[VMC_APDIS_BIT]   = apDis_reg;
    readView[VMC_RXPOL_BIT]   = rxInvert;
    readView[3:2]             = VMC_RSVD32_VAL;
    readView[VMC_BYPASS_BIT]  = bypass_reg;
    readView[VMC_RXGATE_BIT]  = rxGate_reg;
  end

  always_comb begin
    repeater_next = repeater_reg;
    irqPol_next   = irqPol_reg;
    txHiz_next    = txHiz_reg;
    sqeInh_next   = sqeInh_reg;
    natLoop_next  = natLoop_reg;
    apDis_next    = apDis_reg;
    rvsForce_next = rvsForce_reg;
    bypass_next   = bypass_reg;
    rxGate_next   = rxGate_reg;
    rdData_next   = rdData_reg;
    rdValid_next  = 1'b0;
    if (regWrEn && hit) begin
      repeater_next = regWrData[VMC_REPEAT_BIT];
      irqPol_next   = regWrData[VMC_IRQPOL_BIT];
      txHiz_next    = regWrData[VMC_TXHIZ_BIT];
      sqeInh_next   = regWrData[VMC_SQEINH_BIT];
      natLoop_next  = regWrData[VMC_NATLOOP_BIT];
      apDis_next    = regWrData[VMC_APDIS_BIT];
      bypass_next   = regWrData[VMC_BYPASS_BIT];
      rxGate_next   = regWrData[VMC_RXGATE_BIT];
      if (apDis_reg) begin
        rvsForce_next = regWrData[VMC_RXPOL_BIT];
      end
    end
    if (regRdEn) begin
      rdValid_next = 1'b1;
      // Unmapped addresses read as zero
      rdData_next  = hit ? readView : 16'h0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      repeater_reg <= VMC_RESET_VAL[VMC_REPEAT_BIT];
      irqPol_reg   <= VMC_RESET_VAL[VMC_IRQPOL_BIT];
      txHiz_reg    <= VMC_RESET_VAL[VMC_TXHIZ_BIT];
      sqeInh_reg   <= VMC_RESET_VAL[VMC_SQEINH_BIT];
      natLoop_reg  <= VMC_RESET_VAL[VMC_NATLOOP_BIT];
      apDis_reg    <= VMC_RESET_VAL[VMC_APDIS_BIT];
      rvsForce_reg <= VMC_RESET_VAL[VMC_RXPOL_BIT];
      bypass_reg   <= VMC_RESET_VAL[VMC_BYPASS_BIT];
      rxGate_reg   <= VMC_RESET_VAL[VMC_RXGATE_BIT];
      rdData_reg   <= 16'h0000;
      rdValid_reg  <= 1'b0;
    end else begin
      repeater_reg <= repeater_next;
      irqPol_reg   <= irqPol_next;
      txHiz_reg    <= txHiz_next;
      sqeInh_reg   <= sqeInh_next;
      natLoop_reg  <= natLoop_next;
      apDis_reg    <= apDis_next;
      rvsForce_reg <= rvsForce_next;
      bypass_reg   <= bypass_next;
      rxGate_reg   <= rxGate_next;
      rdData_reg   <= rdData_next;
      rdValid_reg  <= rdValid_next;
    end
  end

  assign regRdData  = rdData_reg;
  assign regRdValid = rdValid_reg;

  // ==========================================================
  // SQE test pulse timer
  logic [3:0] sqeCnt_reg, sqeCnt_next;

  always_comb begin
    sqeCnt_next = sqeCnt_reg;
    if (sqeCnt_reg != 4'h0) begin
      sqeCnt_next = sqeCnt_reg - 4'h1;
    end
    if (txDone && mode10m && !sqeInh_reg) begin
      sqeCnt_next = VMC_SQE_CYCLES;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sqeCnt_reg <= 4'h0;
    end else begin
      sqeCnt_reg <= sqeCnt_next;
    end
  end

  // ==========================================================
  // Datapath steering, all outputs registered
  logic [3:0] rxData_reg, rxData_next;
  logic       rxDv_reg, rxDv_next;
  logic       rxBit_reg, rxBit_next;
  logic       txPos_reg, txPos_next;
  logic       txNeg_reg, txNeg_next;
  logic       txOe_reg, txOe_next;
  logic       fdx_reg, fdx_next;
  logic       crs_reg, crs_next;
  logic       irq_reg, irq_next;
  logic       sqe_reg, sqe_next;
  logic       byp_reg, byp_next;
  logic       rxClkEn_reg, rxClkEn_next;

  always_comb begin
    txPos_next = txPosData;
    txNeg_next = txNegData;
    txOe_next  = ~txHiz_reg;
    fdx_next   = duplexRequest & ~repeater_reg;
    crs_next   = repeater_reg ? rxActive : (rxActive | txActive);
    irq_next   = irqPol_reg ? irqEvent : ~irqEvent;
    sqe_next   = (sqeCnt_next != 4'h0);
    byp_next   = bypass_reg & mode100;
    rxClkEn_next = 1'b1;
    if (rxGate_reg && mode100 && !loopbackSelect && !rxActive) begin
      rxClkEn_next = 1'b0;
    end
    if (natLoop_reg && mode10m && macTxEn) begin
      rxData_next = macTxData;
      rxDv_next   = 1'b1;
    end else begin
      rxData_next = lineRxData;
      rxDv_next   = lineRxDv;
    end
    rxBit_next = lineRxBit ^ rxInvert;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rxData_reg  <= 4'h0;
      rxDv_reg    <= 1'b0;
      rxBit_reg   <= 1'b0;
      txPos_reg   <= 1'b0;
      txNeg_reg   <= 1'b0;
      txOe_reg    <= 1'b1;
      fdx_reg     <= 1'b0;
      crs_reg     <= 1'b0;
      irq_reg     <= 1'b1;
      sqe_reg     <= 1'b0;
      byp_reg     <= 1'b0;
      rxClkEn_reg <= 1'b1;
    end else begin
      rxData_reg  <= rxData_next;
      rxDv_reg    <= rxDv_next;
      rxBit_reg   <= rxBit_next;
      txPos_reg   <= txPos_next;
      txNeg_reg   <= txNeg_next;
      txOe_reg    <= txOe_next;
      fdx_reg     <= fdx_next;
      crs_reg     <= crs_next;
      irq_reg     <= irq_next;
      sqe_reg     <= sqe_next;
      byp_reg     <= byp_next;
      rxClkEn_reg <= rxClkEn_next;
    end
  end

  assign rxData         = rxData_reg;
  assign rxDv           = rxDv_reg;
  assign rxBitCorrected = rxBit_reg;
  assign txPosPin       = txPos_reg;
  assign txNegPin       = txNeg_reg;
  assign txPosPinOe     = txOe_reg;
  assign txNegPinOe     = txOe_reg;
  assign fullDuplex     = fdx_reg;
  assign carrierSense   = crs_reg;
  assign phyIrq         = irq_reg;
  assign sqePulse       = sqe_reg;
  assign pcsBypass      = byp_reg;
  assign rxClockEnable  = rxClkEn_reg;
endmodule : vmc_mode_control

//--- vmc_mode_control_chk.sv
`timescale 1ns/1ps
module vmc_mode_control_chk
  import vmc_pkg::*;
(
  // Clock and reset
  input wire logic        mclk, rst_b,
  // Register port
  input wire logic [4:0]  regAddr,
  input wire logic        regWrEn, regRdEn, regRdValid,
  input wire logic [15:0] regWrData, regRdData,
  // Operating state
  input wire logic        mode10m, mode100, loopbackSelect,
  input wire logic        duplexRequest, rxActive, txActive,
  input wire logic        txDone, irqEvent,
  // Outputs watched
  input wire logic        txPosPinOe, txNegPinOe, fullDuplex,
  input wire logic        carrierSense, phyIrq, sqePulse, rxClockEnable
);
  logic [15:0] shwReg;
  logic [15:0] shwNext;
  // Only plain read/write bits of this copy are trusted
  always_comb begin
    shwNext = shwReg;
    if (regWrEn && regAddr == VMC_REG_ADDR) shwNext = regWrData;
  end
  always_ff @(posedge mclk) begin
    shwReg <= rst_b ? shwNext : VMC_RESET_VAL;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_rd_answer: assert property (
    $past(rst_b) |-> regRdValid == $past(regRdEn))
    else $error("read valid lag wrong");
  chk_rsvd_fields: assert property (
    $past(rst_b && regRdEn && regAddr == VMC_REG_ADDR) |->
    regRdData[9:6] == VMC_RSVD96_VAL && regRdData[3:2] == VMC_RSVD32_VAL)
    else $error("reserved field read wrong");
  chk_duplex_repeater: assert property (
    $past(rst_b) |-> fullDuplex == $past(duplexRequest & ~shwReg[15]))
    else $error("full duplex wrong");
  chk_csense_repeater: assert property (
    $past(rst_b) |-> carrierSense ==
    $past(rxActive | (txActive & ~shwReg[15])))
    else $error("carrier sense wrong");
  chk_irq_level: assert property (
    $past(rst_b) |-> phyIrq == $past(irqEvent ~^ shwReg[14]))
    else $error("interrupt polarity wrong");
  chk_tx_release: assert property (
    $past(rst_b) |-> {txPosPinOe, txNegPinOe} == {2{~$past(shwReg[12])}})
    else $error("transmit enable wrong");
  chk_sqe_pulse: assert property (
    txDone && mode10m && !shwReg[11] |=> sqePulse [*8])
    else $error("sqe pulse too short");
  chk_rxclk_gate: assert property (
    $past(rst_b) |-> rxClockEnable ==
    !$past(shwReg[0] & mode100 & ~loopbackSelect & ~rxActive))
    else $error("receive clock gate wrong");
  cover property (txDone && mode10m);
  cover property (regRdValid && regRdData[4]);
  cover property (!rxClockEnable);
endmodule : vmc_mode_control_chk
bind vmc_mode_control vmc_mode_control_chk i_chk (.*);

//--- vmc_mgmt_model.sv
`timescale 1ns/1ps
module vmc_mgmt_model (
  // Clock
  input wire logic         mclk,
  // Register port
  output logic [4:0]       regAddr,
  output logic             regWrEn,
  output logic             regRdEn,
  output logic [15:0]      regWrData,
  input wire logic [15:0]  regRdData,
  input wire logic         regRdValid
);
  initial begin
    {regAddr, regWrEn, regRdEn, regWrData} = '0;
  end
  // Idle lines show the inverse so stale values never pass
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    @(negedge mclk);
    {regAddr, regWrData, regWrEn} = {~a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk);
    {regAddr, regRdEn} = {a, 1'b1};
    @(negedge mclk);
    {regAddr, regRdEn} = {~a, 1'b0};
    d = regRdValid ? regRdData : 16'hXXXX;
  endtask : rd
endmodule : vmc_mgmt_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import vmc_pkg::*;
  logic mclk, rst_b, mode10m, mode100, loopbackSelect, duplexRequest;
  logic rxActive, txActive, txDone, polarityReversed, irqEvent;
  logic txPosData, txNegData, macTxEn, lineRxDv, lineRxBit;
  logic [3:0] macTxData, lineRxData, rxData;
  logic [4:0] regAddr;
  logic regWrEn, regRdEn, regRdValid, rxDv, rxBitCorrected, sqePulse;
  logic [15:0] regWrData, regRdData, rd;
  logic txPosPin, txPosPinOe, txNegPin, txNegPinOe;
  logic fullDuplex, carrierSense, phyIrq, pcsBypass, rxClockEnable;
  int errTotal, nTests, cycles, cnt;
  vmc_mode_control i_dut (.*);
  vmc_mgmt_model i_mgmt (.*);
  // ==========================================================
  // Helpers
  task chk(input logic [15:0] g, input logic [15:0] e);
    nTests++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      errTotal++;
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task report_and_stop;
    $display("tests=%0d errors=%0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Scenarios
  task t_regs;
    i_mgmt.rd(5'h10, rd);
    chk(rd, VMC_RESET_VAL);
    i_mgmt.wr(5'h10, 16'hFFFF);
    i_mgmt.rd(5'h10, rd);
    chk(rd, 16'hDD63);
    i_mgmt.wr(5'h11, 16'h0000);
    i_mgmt.rd(5'h11, rd);
    chk(rd, 16'h0000);
    i_mgmt.wr(5'h10, 16'h0000);
    i_mgmt.rd(5'h10, rd);
    chk(rd, 16'h0140);
  endtask : t_regs
  task t_pol;
    mode10m = 1'b1;
    i_mgmt.wr(5'h10, 16'h0020);
    {polarityReversed, lineRxBit} = 2'b11;
    i_mgmt.wr(5'h10, 16'h0030);
    cyc(3);
    chk(16'(rxBitCorrected), 16'h0000);
    i_mgmt.rd(5'h10, rd);
    chk(rd, 16'h0170);
    i_mgmt.wr(5'h10, 16'h0020);
    cyc(3);
    chk(16'(rxBitCorrected), 16'h0001);
    i_mgmt.wr(5'h10, 16'h0000);
    cyc(3);
    chk(16'(rxBitCorrected), 16'h0000);
    i_mgmt.rd(5'h10, rd);
    chk(rd, 16'h0150);
    polarityReversed = 1'b0;
    i_mgmt.wr(5'h10, 16'h0010);
    cyc(3);
    i_mgmt.rd(5'h10, rd);
    chk(rd, 16'h0140);
  endtask : t_pol
  task t_mode;
    {duplexRequest, txActive, rxActive, irqEvent} = 4'b1101;
    {txPosData, txNegData} = 2'b10;
    i_mgmt.wr(5'h10, 16'hD000);
    cyc(2);
    chk(16'({fullDuplex, carrierSense, phyIrq, txPosPinOe,
             txNegPinOe}), 16'h0004);
    chk(16'({txPosPin, txNegPin}), 16'h0002);
    i_mgmt.wr(5'h10, 16'h0000);
    cyc(2);
    chk(16'({fullDuplex, carrierSense, phyIrq, txPosPinOe,
             txNegPinOe}), 16'h001B);
  endtask : t_mode
  task t_sqe;
    mode10m = 1'b1;
    for (int i = 0; i < 2; i++) begin
      i_mgmt.wr(5'h10, i ? 16'h0800 : 16'h0000);
      txDone = 1'b1;
      cyc(1);
      txDone = 1'b0;
      cnt = 0;
      repeat (14) begin
        if (sqePulse === 1'b1) cnt++;
        cyc(1);
      end
      chk(16'(cnt), i ? 16'h0000 : 16'(VMC_SQE_CYCLES));
    end
  endtask : t_sqe
  task t_path;
    {macTxEn, macTxData, lineRxData} = {1'b1, 4'hA, 4'h3};
    i_mgmt.wr(5'h10, 16'h0400);
    cyc(2);
    chk(16'({rxDv, rxData}), 16'h001A);
    {mode10m, macTxEn, mode100, rxActive} = 4'b0010;
    lineRxDv = 1'b1;
    i_mgmt.wr(5'h10, 16'h0402);
    cyc(2);
    chk(16'(pcsBypass), 16'h0001);
    chk(16'({rxDv, rxData}), 16'h0013);
    i_mgmt.wr(5'h10, 16'h0001);
    cyc(2);
    chk(16'(rxClockEnable), 16'h0000);
    loopbackSelect = 1'b1;
    cyc(2);
    chk(16'(rxClockEnable), 16'h0001);
  endtask : t_path
  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errTotal++;
      report_and_stop;
    end
  end
  initial begin
    {mode10m, mode100, loopbackSelect, duplexRequest, rxActive} = '0;
    {txActive, txDone, polarityReversed, irqEvent, txPosData} = '0;
    {txNegData, macTxEn, lineRxDv, lineRxBit, macTxData} = '0;
    {lineRxData, rst_b} = '0;
    cyc(12);
    rst_b = 1'b1;
    t_regs;
    t_pol;
    t_mode;
    t_sqe;
    t_path;
    report_and_stop;
  end
endmodule : testbench
